/* File: rtl/lcdc_pkg.sv */
// lcdc_pkg: opcodes, defaults, timing counts and the command enumeration
// of the lcd driver command decoder.
// assumes a 10 MHz system clock; nothing here carries state.
package lcdc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;   // system clock period
  localparam int RESET_TIME_NS = 100;   // longest time for the command reset
  // longest time, rounded down, never below one cycle
  localparam int RESET_CYCLES = (RESET_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_TIME_MS = 10;      // calibration reload time
  localparam int CAL_CYCLES = (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int OSC_DIV = 4;           // internal oscillator half period

  // ---------------------------------------------------------------
  // opcode prefixes, longest first
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_INIT = 8'h3a;   // 00111010
  localparam logic [7:0] OP_OTP = 8'hd0;    // 11010000
  localparam logic [6:0] OP_DISP = 7'h1c;   // 0011100x
  localparam logic [6:0] OP_TFILT = 7'h69;  // 1101001x
  localparam logic [5:0] OP_OSC = 6'h33;    // 110011xx
  localparam logic [5:0] OP_CP = 6'h30;
  localparam logic [5:0] OP_TEMP = 6'h32;
  localparam logic [5:0] OP_BIAS = 6'h31;
  localparam logic [5:0] OP_INV = 6'h35;
  localparam logic [4:0] OP_SLA = 5'h03;
  localparam logic [4:0] OP_SLB = 5'h04;
  localparam logic [4:0] OP_SLC = 5'h05;
  localparam logic [4:0] OP_SLD = 5'h06;
  localparam logic [4:0] OP_MUX = 5'h00;
  localparam logic [4:0] OP_IBANK = 5'h01;
  localparam logic [4:0] OP_OBANK = 5'h02;
  localparam logic [3:0] OP_VPRM = 4'h4;
  localparam logic [3:0] OP_VPRL = 4'h5;
  localparam logic [2:0] OP_FRAME = 3'h3;
  localparam logic [1:0] OP_PTR = 2'h2;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_CLK_PIN_OE = 1;    // clock pin output enable
  localparam int BIT_OSC = 0;           // external oscillator select
  localparam logic RST_CLK_PIN_OE = 1'b0;
  localparam logic RST_OSC = 1'b0;
  localparam logic RST_CPE = 1'b0;
  localparam logic RST_CPC = 1'b0;
  localparam logic RST_TCE = 1'b1;
  localparam logic RST_TME = 1'b1;
  localparam logic RST_DISP = 1'b0;
  localparam logic [2:0] RST_MUX = 3'h0;
  localparam logic [1:0] RST_BIAS = 2'h0;
  localparam logic [7:0] RST_VPR = 8'h00;
  localparam logic [4:0] RST_FRAME = 5'h00;
  localparam logic [2:0] RST_SL = 3'h0;
  localparam logic [2:0] RST_BANK = 3'h0;
  localparam logic [5:0] RST_PTR = 6'h00;
  localparam logic RST_LF = 1'b0;
  localparam logic RST_CPF = 1'b0;
  localparam logic RST_TFE = 1'b0;
  // multiplex codes with their own backplane count; others mean eight
  localparam logic [2:0] MUX_STATIC = 3'h1;
  localparam logic [2:0] MUX_TWO = 3'h2;
  localparam logic [2:0] MUX_FOUR = 3'h4;
  localparam logic [2:0] MUX_SIX = 3'h5;

  // command kinds; data phase bytes are not decoded here
  typedef enum logic [4:0] {
    CMD_NONE, CMD_INIT, CMD_OTP, CMD_DISP, CMD_TFILT, CMD_OSC, CMD_CP,
    CMD_TEMP, CMD_BIAS, CMD_INV, CMD_SLA, CMD_SLB, CMD_SLC, CMD_SLD,
    CMD_MUX, CMD_IBANK, CMD_OBANK, CMD_VPRM, CMD_VPRL, CMD_FRAME, CMD_PTR
  } lcdc_cmd_t;

endpackage

/* File: rtl/lcdc_sync.sv */
// lcdc_sync: two flip-flop synchroniser for level signals.
// assumes each bit is a level held long enough to be seen.
`timescale 1ns/1ps
module lcdc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;  // first stage, read only by the second

  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

/* File: rtl/lcdc_link_rx.sv */
// lcdc_link_rx: link side of the command byte crossing, on the link clock.
// assumes the serial framer hands one byte with a one-cycle valid pulse
// and waits for ready; the link clock may stop between frames.
`timescale 1ns/1ps
module lcdc_link_rx (
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic req_o,
  output logic [7:0] byte_o,
  input wire logic ack_i
);
  logic ack_s;  // acknowledge toggle brought into the link domain

  // ---------------------------------------------------------------
  // acknowledge crossing
  // ---------------------------------------------------------------
  lcdc_sync #(.W(1)) u_ack_sync (
    .clk_i(link_clk_i),
    .srst_i(link_srst_i),
    .d_i(ack_i),
    .q_o(ack_s)
  );

  // free while every request has been acknowledged
  assign ready_o = (req_o == ack_s);

  // ---------------------------------------------------------------
  // byte hold and request toggle
  // ---------------------------------------------------------------
  // the byte stays frozen until the system side has answered, so it
  // may be sampled there without a synchroniser of its own
  always_ff @(posedge link_clk_i) begin
    if (link_srst_i) begin
      req_o <= 1'b0;
      byte_o <= 8'h00;
    end else if (valid_i && ready_o) begin
      req_o <= ~req_o;
      byte_o <= byte_i;
    end
  end
endmodule

/* File: rtl/lcdc_decoder.sv */
// lcdc_decoder: command byte decoder with the settings it controls,
// calibration reload sequencing and the clock pin oscillator control.
// assumes command bytes arrive on the link clock; the system clock
// is 10 MHz and unrelated in phase to the link clock.
`timescale 1ns/1ps
module lcdc_decoder #(
  parameter int CAL_CYCLES = lcdc_pkg::CAL_CYCLES,
  parameter int OSC_DIV = lcdc_pkg::OSC_DIV
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // link side
  input wire logic link_clk_i,
  input wire logic link_srst_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  // clock pin, three signals
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  // oscillator and calibration
  output logic osc_ext_o,
  output logic osc_clk_o,
  output logic cal_busy_o,
  output logic cal_done_o,
  // settings
  output logic display_on_o,
  output logic outputs_grounded_o,
  output logic [2:0] mux_mode_o,
  output logic [3:0] backplanes_o,
  output logic charge_pump_en_o,
  output logic charge_pump_x3_o,
  output logic temp_comp_en_o,
  output logic temp_meas_en_o,
  output logic [1:0] bias_mode_o,
  output logic [7:0] vlcd_target_o,
  output logic [4:0] frame_freq_o,
  output logic [2:0] slope_a_o,
  output logic [2:0] slope_b_o,
  output logic [2:0] slope_c_o,
  output logic [2:0] slope_d_o,
  output logic [2:0] input_bank_o,
  output logic [2:0] output_bank_o,
  output logic [5:0] data_ptr_o,
  output logic line_inv_o,
  output logic pump_freq_o,
  output logic temp_filter_o
);
  localparam int CW = $clog2(CAL_CYCLES + 1);  // calibration counter width
  localparam int DW = $clog2(OSC_DIV + 1);     // divider width

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (CAL_CYCLES < 2) begin : g_bad_cal
    $error("calibration count must be at least two cycles");
  end
  if (OSC_DIV < 1) begin : g_bad_div
    $error("oscillator divider must be at least one");
  end
  if (lcdc_pkg::RESET_CYCLES != 1) begin : g_bad_rst
    $error("command reset is built for a single cycle");
  end

  logic link_req;          // request toggle, link domain
  logic [7:0] link_byte;   // held byte, link domain
  logic req_s;             // request toggle after two flops
  logic ack_q;             // acknowledge toggle, back to the link
  logic stb_q;             // one-cycle command strobe
  logic [7:0] byte_q;      // accepted command byte
  lcdc_pkg::lcdc_cmd_t kind;  // decoded command of byte_q
  logic init_cmd;          // initialize accepted this cycle
  logic cal_start;         // calibration reload trigger
  logic boot_q;            // first cycle after reset release
  logic [CW-1:0] cal_cnt_q;
  logic [DW-1:0] div_q;
  logic osc_int_q;         // internal oscillator level
  logic ext_s;             // clock pin level after two flops
  logic pin_drive_q;       // clock_pin_output_enable setting

  // ---------------------------------------------------------------
  // link crossing
  // ---------------------------------------------------------------
  lcdc_link_rx u_link (
    .link_clk_i(link_clk_i),
    .link_srst_i(link_srst_i),
    .byte_i(cmd_byte_i),
    .valid_i(cmd_valid_i),
    .ready_o(cmd_ready_o),
    .req_o(link_req),
    .byte_o(link_byte),
    .ack_i(ack_q)
  );

  lcdc_sync #(.W(1)) u_req_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(link_req),
    .q_o(req_s)
  );

  // a toggle difference marks a new byte; the held byte is stable
  // until ack_q is seen on the link side, so sampling it is safe.
  // ack_q is not touched by initialize, so the link keeps working
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      stb_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      stb_q <= (req_s != ack_q);
      if (req_s != ack_q) begin
        ack_q <= req_s;
        byte_q <= link_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // decode, longest prefix first
  // ---------------------------------------------------------------
  // undefined bytes decode as none and change nothing
  always_comb begin
    if (byte_q == lcdc_pkg::OP_INIT) kind = lcdc_pkg::CMD_INIT;
    else if (byte_q == lcdc_pkg::OP_OTP) kind = lcdc_pkg::CMD_OTP;
    else if (byte_q[7:1] == lcdc_pkg::OP_DISP) kind = lcdc_pkg::CMD_DISP;
    else if (byte_q[7:1] == lcdc_pkg::OP_TFILT) kind = lcdc_pkg::CMD_TFILT;
    else if (byte_q[7:2] == lcdc_pkg::OP_OSC) kind = lcdc_pkg::CMD_OSC;
    else if (byte_q[7:2] == lcdc_pkg::OP_CP) kind = lcdc_pkg::CMD_CP;
    else if (byte_q[7:2] == lcdc_pkg::OP_TEMP) kind = lcdc_pkg::CMD_TEMP;
    else if (byte_q[7:2] == lcdc_pkg::OP_BIAS) kind = lcdc_pkg::CMD_BIAS;
    else if (byte_q[7:2] == lcdc_pkg::OP_INV) kind = lcdc_pkg::CMD_INV;
    else if (byte_q[7:3] == lcdc_pkg::OP_SLA) kind = lcdc_pkg::CMD_SLA;
    else if (byte_q[7:3] == lcdc_pkg::OP_SLB) kind = lcdc_pkg::CMD_SLB;
    else if (byte_q[7:3] == lcdc_pkg::OP_SLC) kind = lcdc_pkg::CMD_SLC;
    else if (byte_q[7:3] == lcdc_pkg::OP_SLD) kind = lcdc_pkg::CMD_SLD;
    else if (byte_q[7:3] == lcdc_pkg::OP_MUX) kind = lcdc_pkg::CMD_MUX;
    else if (byte_q[7:3] == lcdc_pkg::OP_IBANK) kind = lcdc_pkg::CMD_IBANK;
    else if (byte_q[7:3] == lcdc_pkg::OP_OBANK) kind = lcdc_pkg::CMD_OBANK;
    else if (byte_q[7:4] == lcdc_pkg::OP_VPRM) kind = lcdc_pkg::CMD_VPRM;
    else if (byte_q[7:4] == lcdc_pkg::OP_VPRL) kind = lcdc_pkg::CMD_VPRL;
    else if (byte_q[7:5] == lcdc_pkg::OP_FRAME) kind = lcdc_pkg::CMD_FRAME;
    else if (byte_q[7:6] == lcdc_pkg::OP_PTR) kind = lcdc_pkg::CMD_PTR;
    else kind = lcdc_pkg::CMD_NONE;
  end

  assign init_cmd = stb_q && (kind == lcdc_pkg::CMD_INIT);

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  // initialize acts like reset in the very next edge, which is one
  // 100 ns cycle; other commands only touch their own fields
  always_ff @(posedge clk_i) begin
    if (srst_i || init_cmd) begin
      pin_drive_q <= lcdc_pkg::RST_CLK_PIN_OE;
      osc_ext_o <= lcdc_pkg::RST_OSC;
      charge_pump_en_o <= lcdc_pkg::RST_CPE;
      charge_pump_x3_o <= lcdc_pkg::RST_CPC;
      temp_comp_en_o <= lcdc_pkg::RST_TCE;
      temp_meas_en_o <= lcdc_pkg::RST_TME;
      display_on_o <= lcdc_pkg::RST_DISP;
      mux_mode_o <= lcdc_pkg::RST_MUX;
      bias_mode_o <= lcdc_pkg::RST_BIAS;
      vlcd_target_o <= lcdc_pkg::RST_VPR;
      frame_freq_o <= lcdc_pkg::RST_FRAME;
      slope_a_o <= lcdc_pkg::RST_SL;
      slope_b_o <= lcdc_pkg::RST_SL;
      slope_c_o <= lcdc_pkg::RST_SL;
      slope_d_o <= lcdc_pkg::RST_SL;
      input_bank_o <= lcdc_pkg::RST_BANK;
      output_bank_o <= lcdc_pkg::RST_BANK;
      data_ptr_o <= lcdc_pkg::RST_PTR;
      line_inv_o <= lcdc_pkg::RST_LF;
      pump_freq_o <= lcdc_pkg::RST_CPF;
      temp_filter_o <= lcdc_pkg::RST_TFE;
    end else if (stb_q) begin
      case (kind)
        lcdc_pkg::CMD_OSC: begin
          pin_drive_q <= byte_q[lcdc_pkg::BIT_CLK_PIN_OE];
          osc_ext_o <= byte_q[lcdc_pkg::BIT_OSC];
        end
        lcdc_pkg::CMD_CP: begin
          charge_pump_en_o <= byte_q[1];
          charge_pump_x3_o <= byte_q[0];
        end
        lcdc_pkg::CMD_TEMP: begin
          temp_comp_en_o <= byte_q[1];
          temp_meas_en_o <= byte_q[0];
        end
        lcdc_pkg::CMD_DISP: display_on_o <= byte_q[0];
        lcdc_pkg::CMD_MUX: mux_mode_o <= byte_q[2:0];
        lcdc_pkg::CMD_BIAS: bias_mode_o <= byte_q[1:0];
        lcdc_pkg::CMD_VPRM: vlcd_target_o[7:4] <= byte_q[3:0];
        lcdc_pkg::CMD_VPRL: vlcd_target_o[3:0] <= byte_q[3:0];
        lcdc_pkg::CMD_FRAME: frame_freq_o <= byte_q[4:0];
        lcdc_pkg::CMD_SLA: slope_a_o <= byte_q[2:0];
        lcdc_pkg::CMD_SLB: slope_b_o <= byte_q[2:0];
        lcdc_pkg::CMD_SLC: slope_c_o <= byte_q[2:0];
        lcdc_pkg::CMD_SLD: slope_d_o <= byte_q[2:0];
        lcdc_pkg::CMD_IBANK: input_bank_o <= byte_q[2:0];
        lcdc_pkg::CMD_OBANK: output_bank_o <= byte_q[2:0];
        lcdc_pkg::CMD_PTR: data_ptr_o <= byte_q[5:0];
        lcdc_pkg::CMD_INV: begin
          line_inv_o <= byte_q[1];
          pump_freq_o <= byte_q[0];
        end
        lcdc_pkg::CMD_TFILT: temp_filter_o <= byte_q[0];
        default: begin
          // refresh, none: no setting changes
        end
      endcase
    end
  end

  // display off ties backplanes and segments to ground
  assign outputs_grounded_o = ~display_on_o;

  // backplane count from the multiplex code
  always_comb begin
    case (mux_mode_o)
      lcdc_pkg::MUX_STATIC: backplanes_o = 4'h1;
      lcdc_pkg::MUX_TWO: backplanes_o = 4'h2;
      lcdc_pkg::MUX_FOUR: backplanes_o = 4'h4;
      lcdc_pkg::MUX_SIX: backplanes_o = 4'h6;
      default: backplanes_o = 4'h8;
    endcase
  end

  // ---------------------------------------------------------------
  // calibration reload
  // ---------------------------------------------------------------
  // boot_q gives the power-on reload one cycle after reset release;
  // a new trigger during a reload restarts the full count
  assign cal_start = boot_q || init_cmd ||
                     (stb_q && (kind == lcdc_pkg::CMD_OTP));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cal_cnt_q <= '0;
      cal_done_o <= 1'b0;
    end else begin
      cal_done_o <= (cal_cnt_q == CW'(1)) && !cal_start;
      if (cal_start) begin
        cal_cnt_q <= CW'(CAL_CYCLES);
      end else if (cal_cnt_q != '0) begin
        cal_cnt_q <= cal_cnt_q - CW'(1);
      end
    end
  end

  assign cal_busy_o = (cal_cnt_q != '0);

  // ---------------------------------------------------------------
  // oscillator and clock pin
  // ---------------------------------------------------------------
  lcdc_sync #(.W(1)) u_pin_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(clk_pin_i),
    .q_o(ext_s)
  );

  // internal oscillator stands for the on-chip one; it is only a
  // divided system clock, so its frequency is coarse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_q <= '0;
      osc_int_q <= 1'b0;
    end else if (div_q == DW'(OSC_DIV - 1)) begin
      div_q <= '0;
      osc_int_q <= ~osc_int_q;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // the pin is driven only with enable set and the internal source;
  // external mode turns it into an input whatever enable says
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_pin_o <= 1'b0;
      clk_pin_oe_o <= 1'b0;
      osc_clk_o <= 1'b0;
    end else begin
      clk_pin_o <= osc_int_q;
      clk_pin_oe_o <= pin_drive_q && !osc_ext_o;
      osc_clk_o <= osc_ext_o ? ext_s : osc_int_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_prefix_ptr: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q[7:6] == 2'h2 |=> data_ptr_o == $past(byte_q[5:0]))
    else $error("pointer command not taken");
  a_init_defaults: assert property (@(posedge clk_i) disable iff (srst_i)
    init_cmd |=> !display_on_o && mux_mode_o == 3'h0 && temp_comp_en_o
      && !pin_drive_q && vlcd_target_o == 8'h00)
    else $error("initialize left a setting changed");
  a_link_after_init: assert property (@(posedge clk_i) disable iff (srst_i)
    init_cmd ##1 (req_s != ack_q) |=> stb_q)
    else $error("byte after initialize not accepted");
  a_reset_time: assert property (@(posedge clk_i) disable iff (srst_i)
    init_cmd |=> !osc_ext_o ##1 !clk_pin_oe_o)
    else $error("initialize reset too slow");
  a_cal_trigger: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q == 8'hd0 |=> cal_busy_o && cal_cnt_q == CW'(CAL_CYCLES))
    else $error("refresh did not start reload");
  a_cal_length: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(cal_busy_o) |-> $past(cal_cnt_q) == CW'(1) && cal_done_o)
    else $error("reload ended at wrong count");
  a_pin_drive: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q == 8'hce ##1 !stb_q |=> clk_pin_oe_o)
    else $error("clock pin not driven");
  a_ext_input: assert property (@(posedge clk_i) disable iff (srst_i)
    osc_ext_o ##1 osc_ext_o |-> !clk_pin_oe_o)
    else $error("clock pin driven in external mode");
  a_disp_ground: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q == 8'h38 |=> outputs_grounded_o)
    else $error("display off not grounded");
  a_mux_six: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q == 8'h05 |=> backplanes_o == 4'h6)
    else $error("six backplane code wrong");
  a_only_addr: assert property (@(posedge clk_i) disable iff (srst_i)
    stb_q && byte_q[7:5] == 3'h3 |=> $stable(vlcd_target_o) && $stable(data_ptr_o))
    else $error("frame command touched other setting");
endmodule

/* File: tb/lcdc_host_model.sv */
// lcdc_host_model: host side of the command link, makes the link clock.
// assumes the decoder's ready/valid toggle handshake on the link clock.
`timescale 1ns/1ps
module lcdc_host_model (
  output logic link_clk_o,
  output logic link_srst_o,
  output logic [7:0] byte_o,
  output logic valid_o,
  input wire logic ready_i
);
  // ------------------------------------------------------------
  // link clock, 12 ns, stands low outside transfers
  // ------------------------------------------------------------
  initial begin
    link_clk_o = 1'b0;
    link_srst_o = 1'b1;
    byte_o = 8'hff;
    valid_o = 1'b0;
  end
  // one link clock period; signals change only in the low phase
  task automatic tick();
    #6 link_clk_o = 1'b1;
    #6 link_clk_o = 1'b0;
  endtask
  // reset of the link domain, longer than the one edge needed
  task automatic reset_link();
    link_srst_o = 1'b1;
    repeat (4) tick();
    link_srst_o = 1'b0;
    tick();
  endtask
  // ------------------------------------------------------------
  // one command byte; callers pass defined opcodes only
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    n = 0;
    // a byte offered while ready is low would be lost, so wait first
    while (ready_i !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    byte_o = b;
    valid_o = 1'b1;
    tick();
    valid_o = 1'b0;
    // released data line shows the inverse, never the last value
    byte_o = ~b;
    n = 0;
    // clock keeps running until the answer comes back
    while (ready_i !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    ok = (ready_i === 1'b1);
  endtask
endmodule

/* File: tb/lcd_driver_command_decoder_test.sv */
// lcd_driver_command_decoder_test: command sequences with expected settings.
// assumes the host model drives the link; reload count shortened to 20.
`timescale 1ns/1ps
module lcd_driver_command_decoder_test;
  localparam int CAL = 20; // shortened reload count
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic clk_pin_i = 1'b0;
  logic link_clk, link_srst, cmd_valid, cmd_ready;
  logic [7:0] cmd_byte, vlcd;
  logic pin_oe, osc_ext, osc_clk, busy, done, disp, gnd, tce, tfe;
  logic [2:0] mux;
  logic [3:0] bps;
  logic [3:0] exp_bp;
  logic [4:0] frm;
  logic [5:0] ptr;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  bit ok;
  always #50 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  lcdc_host_model i_lcdc_host_model (.link_clk_o(link_clk), .link_srst_o(link_srst),
    .byte_o(cmd_byte), .valid_o(cmd_valid), .ready_i(cmd_ready));
  lcdc_decoder #(.CAL_CYCLES(CAL), .OSC_DIV(4)) i_lcdc_decoder (.clk_i(clk_i),
    .srst_i(srst_i), .link_clk_i(link_clk), .link_srst_i(link_srst),
    .cmd_byte_i(cmd_byte), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .clk_pin_i(clk_pin_i), .clk_pin_o(), .clk_pin_oe_o(pin_oe), .osc_ext_o(osc_ext),
    .osc_clk_o(osc_clk), .cal_busy_o(busy), .cal_done_o(done), .display_on_o(disp),
    .outputs_grounded_o(gnd), .mux_mode_o(mux), .backplanes_o(bps),
    .charge_pump_en_o(), .charge_pump_x3_o(), .temp_comp_en_o(tce), .temp_meas_en_o(),
    .bias_mode_o(), .vlcd_target_o(vlcd), .frame_freq_o(frm), .slope_a_o(), .slope_b_o(),
    .slope_c_o(), .slope_d_o(), .input_bank_o(), .output_bank_o(), .data_ptr_o(ptr),
    .line_inv_o(), .pump_freq_o(), .temp_filter_o(tfe));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // send a byte, then let the four-edge update land before checking
  task automatic cmd(input logic [7:0] b);
    i_lcdc_host_model.send(b, ok);
    chk("ready", 8'h01, {7'h00, ok});
    repeat (6) @(negedge clk_i);
  endtask
  // reload must end near the shortened count, not early and not never
  task automatic wait_cal();
    int n;
    n = 0;
    while (done !== 1'b1 && n < CAL + 10) begin
      @(negedge clk_i);
      n++;
    end
    chk("cal_len", 8'h01, {7'h00, (n >= CAL - 8) && (n <= CAL + 4)});
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_lcdc_host_model.reset_link();
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    chk("disp", 8'h00, {7'h00, disp});
    chk("gnd", 8'h01, {7'h00, gnd});
    chk("oe", 8'h00, {7'h00, pin_oe});
    chk("ext", 8'h00, {7'h00, osc_ext});
    wait_cal();
    cmd(8'h3a);
    wait_cal();
    cmd(8'h39);
    chk("disp", 8'h01, {7'h00, disp});
    chk("gnd", 8'h00, {7'h00, gnd});
    cmd(8'h38);
    chk("gnd", 8'h01, {7'h00, gnd});
    cmd(8'h39);
    // every multiplex code; codes without their own count mean eight
    for (int c = 0; c < 8; c++) begin
      cmd({5'h00, 3'(c)});
      exp_bp = (c == 1) ? 4'h1 : (c == 2) ? 4'h2 : (c == 4) ? 4'h4 : (c == 5) ? 4'h6 : 4'h8;
      chk("mux", 8'(c), {5'h00, mux});
      chk("backplanes", {4'h0, exp_bp}, {4'h0, bps});
    end
    cmd(8'hce);
    chk("oe", 8'h01, {7'h00, pin_oe});
    cmd(8'hcf);
    chk("ext", 8'h01, {7'h00, osc_ext});
    chk("oe", 8'h00, {7'h00, pin_oe});
    clk_pin_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("osc_clk", 8'h01, {7'h00, osc_clk});
    cmd(8'hce);
    // temp filter prefix must win over the refresh pattern
    cmd(8'hd3);
    chk("tfe", 8'h01, {7'h00, tfe});
    chk("busy", 8'h00, {7'h00, busy});
    cmd(8'h4a);
    cmd(8'h55);
    chk("vlcd", 8'ha5, vlcd);
    cmd(8'h67);
    chk("frame", 8'h07, {3'h0, frm});
    chk("vlcd", 8'ha5, vlcd);
    cmd(8'h9b);
    chk("ptr", 8'h1b, {2'h0, ptr});
    i_lcdc_host_model.send(8'h3a, ok);
    // poll until reset lands, then everything must be back together
    for (int n = 0; n < 10 && disp !== 1'b0; n++) @(negedge clk_i);
    chk("disp", 8'h00, {7'h00, disp});
    chk("vlcd", 8'h00, vlcd);
    // the pin enable is registered from the setting, one cycle later
    @(negedge clk_i);
    chk("oe", 8'h00, {7'h00, pin_oe});
    chk("tfe", 8'h00, {7'h00, tfe});
    chk("tce", 8'h01, {7'h00, tce});
    wait_cal();
    cmd(8'h39);
    chk("disp", 8'h01, {7'h00, disp});
    cmd(8'hd0);
    chk("busy", 8'h01, {7'h00, busy});
    chk("disp", 8'h01, {7'h00, disp});
    wait_cal();
    report_and_stop();
  end
endmodule
